// ===== rtl/irqgp_pkg.sv
// irqgp_pkg: constants for the interrupt and gpio routing block.
// assumes a 32-bit apb slave and four general-purpose pins.
package irqgp_pkg;
  localparam int NUM_PINS = 4;
  // apb byte addresses
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_ENABLES = 8'h04;
  localparam logic [7:0] ADDR_PIN0_CONF = 8'h10;
  // event flag positions
  localparam int EV_RX_READY = 0;
  localparam int EV_RX_DISCARD = 1;
  localparam int EV_TX_SENT = 2;
  localparam int EV_MAX_RETX = 3;
  localparam int EV_CRC_ERR = 4;
  localparam int EV_TXF_ERR = 5;
  localparam int EV_RXF_ERR = 6;
  localparam int EV_TXF_AFULL = 7;
  localparam int EV_TXF_AEMPTY = 8;
  localparam int EV_RXF_AFULL = 9;
  localparam int EV_RXF_AEMPTY = 10;
  localparam int EV_MAX_BACKOFF = 11;
  localparam int EV_PREAMBLE = 12;
  localparam int EV_SYNC = 13;
  localparam int EV_CARRIER = 14;
  localparam int EV_WAKEUP_TO = 15;
  localparam int EV_READY = 16;
  localparam int EV_STBY_SWITCH = 17;
  localparam int EV_LOW_BATT = 18;
  localparam int EV_POR = 19;
  localparam int EV_RX_TIMEOUT = 28;
  localparam int EV_SNIFF_TIMEOUT = 29;
  // implemented flag bits (others reserved, read zero)
  localparam logic [31:0] FLAG_IMPL = 32'h300f_ffff;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLES_RESET = 32'h0000_0000;
  // pin configuration byte layout
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 3;
  localparam int MODE_HI = 1;
  localparam int MODE_LO = 0;
  localparam logic [7:0] PIN0_CONF_RESET = 8'h0a;
  localparam logic [7:0] PINX_CONF_RESET = 8'ha2;
  localparam logic [7:0] CONF_WR_MASK = 8'hfb;
  typedef enum logic [1:0] {
    IRQGP_MODE_ANALOG = 2'b00,
    IRQGP_MODE_IN = 2'b01,
    IRQGP_MODE_OUT_LP = 2'b10,
    IRQGP_MODE_OUT_HP = 2'b11
  } irqgp_mode_t;
  // input function codes
  localparam logic [4:0] IN_TX_CMD = 5'h00;
  localparam logic [4:0] IN_RX_CMD = 5'h01;
  localparam logic [4:0] IN_TX_DATA = 5'h02;
  localparam logic [4:0] IN_WAKEUP = 5'h03;
  localparam logic [4:0] IN_LF_CLK = 5'h04;
endpackage

// ===== rtl/irqgp_top.sv
// irqgp_top: event flags, enables, irq line and gpio signal routing.
// assumes apb master on MCLK; event inputs are MCLK-domain pulses/levels.
//
// Overview of operation
// - irq request leaves on any gpio chosen by its selection code
// - flag bits 0..6: rx ready, discard, tx sent, retx, crc, fifo errors
// - flag bits 7..11: fifo almost full/empty flags and max back-off
// - flag bits 12..14: preamble, sync word, carrier sense
// - bits 15..19 wakeup, ready, standby, battery, por; 28..29 timers
// - wakeup timeout flag set only once crystal clock is available
// - ready flag set on each entry to ready after crystal settles
// - reading the flag register clears it
// - a flag goes high when its event occurs
// - each event has an enable bit; zero blocks its request
// - output code 0 drives the active-low irq request
// - codes 1..3: inverted por, wakeup expired, low battery
// - codes 4..10: tx clock, tx cmd, fifo flags, rx data/clock, rx state
// - codes 11..18: state levels, antenna, preamble, sync, cs, rsv, txrx
// - codes 19 and 20 drive constant high and constant low
// - codes 21..30 regulator, state and wait levels, synth; 31 reserved
// - input codes 0,1,2: tx command, rx command, direct tx data
// - input code 3 external wakeup, 4 low-frequency clock; rest unused
// - config byte: select in 7:3, bit 2 reserved, mode in 1:0
// - mode 01 input, 10 low-power out, 11 high-power out
`timescale 1ns/100ps
`default_nettype none
module irqgp_top (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [31:0] EVENT_PULSE,
  input wire logic XO_CLK_AVAILABLE,
  input wire logic [31:0] STATUS_LEVELS,
  input wire logic [3:0] GPIO_IN,
  output logic [3:0] GPIO_OUT,
  output logic [3:0] GPIO_OE,
  output logic [3:0] GPIO_HIGH_DRIVE,
  output logic TX_CMD,
  output logic RX_CMD,
  output logic TX_DIRECT_DATA,
  output logic EXT_WAKEUP,
  output logic LF_CLK_IN
);
  // STATUS_LEVELS carries the internal level for output code n on bit n.
  localparam int NP = irqgp_pkg::NUM_PINS;

  logic [31:0] flags_reg;
  logic [31:0] enables_reg;
  logic [7:0] conf_reg [NP];
  logic wake_pend_reg;
  logic [NP-1:0] gin_s1_reg;
  logic [NP-1:0] gin_s2_reg;
  logic [31:0] lev_s1_reg;
  logic [31:0] lev_s2_reg;
  logic irq_n_reg;
  logic irq_n_next;
  logic [31:0] set_vec;
  logic apb_setup;
  logic rd_flags;
  logic wr_en;

  function automatic logic [1:0] pin_index(input logic [7:0] a);
    return 2'(a - irqgp_pkg::ADDR_PIN0_CONF >> 2);
  endfunction

  function automatic logic is_pin_addr(input logic [7:0] a);
    return a >= irqgp_pkg::ADDR_PIN0_CONF &&
           a < irqgp_pkg::ADDR_PIN0_CONF + 8'(4 * NP) && a[1:0] == 2'b00;
  endfunction

  // zero-wait slave: answer in the access cycle itself
  assign apb_setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_flags = PSEL && PENABLE && !PWRITE &&
                    PADDR == irqgp_pkg::ADDR_FLAGS;

  // pins and status levels come from other domains
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      gin_s1_reg <= '0;
      gin_s2_reg <= '0;
      lev_s1_reg <= '0;
      lev_s2_reg <= '0;
    end else begin
      gin_s1_reg <= GPIO_IN;
      gin_s2_reg <= gin_s1_reg;
      lev_s1_reg <= STATUS_LEVELS;
      lev_s2_reg <= lev_s1_reg;
    end
  end

  // wakeup expiry waits here until the crystal clock is usable
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      wake_pend_reg <= 1'b0;
    end else if (XO_CLK_AVAILABLE) begin
      wake_pend_reg <= 1'b0;
    end else if (EVENT_PULSE[irqgp_pkg::EV_WAKEUP_TO]) begin
      wake_pend_reg <= 1'b1;
    end
  end

  always_comb begin
    set_vec = EVENT_PULSE & irqgp_pkg::FLAG_IMPL;
    set_vec[irqgp_pkg::EV_WAKEUP_TO] = XO_CLK_AVAILABLE &&
      (EVENT_PULSE[irqgp_pkg::EV_WAKEUP_TO] || wake_pend_reg);
    // ready counts only once the crystal has settled
    set_vec[irqgp_pkg::EV_READY] = EVENT_PULSE[irqgp_pkg::EV_READY] &&
      XO_CLK_AVAILABLE;
  end

  // set beats the clear-on-read in the same cycle
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      flags_reg <= irqgp_pkg::FLAGS_RESET;
    end else if (rd_flags) begin
      flags_reg <= set_vec;
    end else begin
      flags_reg <= flags_reg | set_vec;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      enables_reg <= irqgp_pkg::ENABLES_RESET;
    end else if (wr_en && PADDR == irqgp_pkg::ADDR_ENABLES) begin
      enables_reg <= PWDATA & irqgp_pkg::FLAG_IMPL;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      conf_reg[0] <= irqgp_pkg::PIN0_CONF_RESET;
      for (int i = 1; i < NP; i++) begin
        conf_reg[i] <= irqgp_pkg::PINX_CONF_RESET;
      end
    end else if (wr_en && is_pin_addr(PADDR)) begin
      // bit 2 stays zero
      conf_reg[pin_index(PADDR)] <= PWDATA[7:0] &
        irqgp_pkg::CONF_WR_MASK;
    end
  end

  // active low while any enabled flag is set
  assign irq_n_next = ~|(flags_reg & enables_reg);

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= irq_n_next;
    end
  end

  // pin output mux; irq_n_reg adds one cycle after the flag
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_pin
      logic [4:0] sel;
      logic [1:0] mode;
      logic src;
      assign sel = conf_reg[g][irqgp_pkg::SEL_HI:irqgp_pkg::SEL_LO];
      assign mode = conf_reg[g][irqgp_pkg::MODE_HI:irqgp_pkg::MODE_LO];
      always_comb begin
        if (sel == 5'h00) begin
          src = irq_n_reg;
        end else if (sel == 5'h13) begin
          src = 1'b1;
        end else if (sel == 5'h14 || sel == 5'h11 || sel == 5'h1f) begin
          src = 1'b0;
        end else begin
          src = lev_s2_reg[sel];
        end
      end
      always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
          GPIO_OUT[g] <= 1'b0;
          GPIO_OE[g] <= 1'b0;
          GPIO_HIGH_DRIVE[g] <= 1'b0;
        end else begin
          GPIO_OUT[g] <= src;
          GPIO_OE[g] <= mode[1];
          GPIO_HIGH_DRIVE[g] <= mode == irqgp_pkg::IRQGP_MODE_OUT_HP;
        end
      end
    end
  endgenerate

  // input functions: or of every pin in input mode with that code
  function automatic logic in_func(input logic [4:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NP; i++) begin
      if (conf_reg[i][1:0] == irqgp_pkg::IRQGP_MODE_IN &&
          conf_reg[i][7:3] == code) begin
        r = r | gin_s2_reg[i];
      end
    end
    return r;
  endfunction

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      TX_CMD <= 1'b0;
      RX_CMD <= 1'b0;
      TX_DIRECT_DATA <= 1'b0;
      EXT_WAKEUP <= 1'b0;
      LF_CLK_IN <= 1'b0;
    end else begin
      TX_CMD <= in_func(irqgp_pkg::IN_TX_CMD);
      RX_CMD <= in_func(irqgp_pkg::IN_RX_CMD);
      TX_DIRECT_DATA <= in_func(irqgp_pkg::IN_TX_DATA);
      EXT_WAKEUP <= in_func(irqgp_pkg::IN_WAKEUP);
      LF_CLK_IN <= in_func(irqgp_pkg::IN_LF_CLK);
    end
  end

  // read data registered at setup, so pready can be high in access
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA <= '0;
      PSLVERR <= 1'b0;
      PREADY <= 1'b0;
    end else begin
      PREADY <= apb_setup;
      PSLVERR <= 1'b0;
      if (apb_setup) begin
        if (PADDR == irqgp_pkg::ADDR_FLAGS) begin
          PRDATA <= flags_reg | set_vec;
        end else if (PADDR == irqgp_pkg::ADDR_ENABLES) begin
          PRDATA <= enables_reg;
        end else if (is_pin_addr(PADDR)) begin
          PRDATA <= {24'h000000, conf_reg[pin_index(PADDR)]};
        end else begin
          PRDATA <= '0;
          PSLVERR <= 1'b1;
        end
      end
    end
  end
endmodule // irqgp_top
`default_nettype wire

// ===== tb/irqgp_asserts.sv
// irqgp_asserts: apb timing, flag and pin mode checks on irqgp_top.
// assumes one MCLK domain and the map of irqgp_pkg.
`timescale 1ns/100ps
`default_nettype none
module irqgp_asserts (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [31:0] EVENT_PULSE,
  input wire logic XO_CLK_AVAILABLE,
  input wire logic [3:0] GPIO_OE,
  input wire logic [3:0] GPIO_HIGH_DRIVE
);
  logic mapped;
  logic flag_rd;
  assign mapped = PADDR inside {8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c};
  assign flag_rd = !PWRITE && PADDR == 8'h00;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  a_ready_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_ready_single: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_err_unmapped: assert property (PREADY && !mapped
    |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
    else $error("unmapped access not refused");
  a_read_clears: assert property (
    PREADY && flag_rd && EVENT_PULSE == 32'h0 && $past(XO_CLK_AVAILABLE)
    && XO_CLK_AVAILABLE ##1 PSEL && !PENABLE && flag_rd
    && EVENT_PULSE == 32'h0 && XO_CLK_AVAILABLE |=> PRDATA == 32'h0)
    else $error("flags survive a read");
  a_flag_sets: assert property (
    EVENT_PULSE[2] ##1 PSEL && !PENABLE && flag_rd |=> PRDATA[2])
    else $error("event did not set flag");
  a_flag_rsv: assert property (
    PREADY && flag_rd |-> (PRDATA & ~irqgp_pkg::FLAG_IMPL) == 32'h0)
    else $error("reserved flag bit set");
  a_conf_read: assert property (
    PREADY && !PWRITE && PADDR[7:4] == 4'h1
    |-> PRDATA[31:8] == 24'h0 && !PRDATA[2])
    else $error("conf reserved bits not zero");
  a_pin0_mode: assert property (
    PREADY && PSEL && PENABLE && PWRITE && PADDR == 8'h10
    |-> ##2 GPIO_OE[0] == $past(PWDATA[1], 2) && GPIO_HIGH_DRIVE[0]
    == ($past(PWDATA[1], 2) && $past(PWDATA[0], 2)))
    else $error("pin0 drive mode wrong");
endmodule // irqgp_asserts
bind irqgp_top irqgp_asserts u_chk (.MCLK, .RESETN, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .EVENT_PULSE,
  .XO_CLK_AVAILABLE, .GPIO_OE, .GPIO_HIGH_DRIVE);
`default_nettype wire

// ===== tb/irqgp_host.sv
// irqgp_host: host side of the four pins, with pull-ups.
// assumes the host drives only pins the device has released.
`timescale 1ns/100ps
`default_nettype none
module irqgp_host (
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] host_drv,
  input wire logic [3:0] host_oe,
  output logic [3:0] pin_lvl
);
  // pull-up keeps an idle irq line inactive
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dev_oe[i]) pin_lvl[i] = dev_out[i];
      else if (host_oe[i]) pin_lvl[i] = host_drv[i];
      else pin_lvl[i] = 1'b1;
    end
  end
endmodule // irqgp_host
`default_nettype wire

// ===== tb/irq_and_gpio_routing_tb_top.sv
// irq_and_gpio_routing_tb_top: irq table, then flag and pin cases.
// assumes irqgp_top with the host pin model.
`timescale 1ns/100ps
`default_nettype none
module irq_and_gpio_routing_tb_top;
  logic MCLK = 1'b0, RESETN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, XO_CLK_AVAILABLE = 1'b1, PREADY, PSLVERR, slverr;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, EVENT_PULSE = 32'h0, STATUS_LEVELS = 32'h0;
  logic [31:0] PRDATA, rdata;
  logic [3:0] pin_lvl, GPIO_OUT, GPIO_OE, GPIO_HIGH_DRIVE;
  logic [3:0] host_drv = 4'h0, host_oe = 4'h0;
  logic TX_CMD, RX_CMD, TX_DIRECT_DATA, EXT_WAKEUP, LF_CLK_IN;
  logic [4:0] fn;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  typedef struct {int b; logic [31:0] en; logic irq_n;} irqgp_row_t;
  irqgp_row_t rows[8] = '{'{0, 32'hffff_ffff, 1'b0},
    '{5, 32'hffff_ffff, 1'b0}, '{11, 32'hffff_ffff, 1'b0},
    '{14, 32'h0000_4000, 1'b0}, '{19, 32'hffff_ffff, 1'b0},
    '{28, 32'hffff_ffff, 1'b0}, '{29, 32'h2000_0000, 1'b0},
    '{3, 32'hffff_fff7, 1'b1}};
  assign fn = {LF_CLK_IN, EXT_WAKEUP, TX_DIRECT_DATA, RX_CMD, TX_CMD};
  irqgp_top i_dut (.MCLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .EVENT_PULSE, .XO_CLK_AVAILABLE,
    .STATUS_LEVELS, .GPIO_IN(pin_lvl), .GPIO_OUT, .GPIO_OE,
    .GPIO_HIGH_DRIVE, .TX_CMD, .RX_CMD, .TX_DIRECT_DATA, .EXT_WAKEUP,
    .LF_CLK_IN);
  irqgp_host i_host (.dev_out(GPIO_OUT), .dev_oe(GPIO_OE),
    .host_drv(host_drv), .host_oe(host_oe), .pin_lvl(pin_lvl));
  always #12.5 MCLK = ~MCLK;
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until pready is sampled; release left to the caller
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n == 20) error_cnt++;
    rdata = PRDATA;
    slverr = PSLVERR;
  endtask
  task automatic idle();
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle();
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    idle();
  endtask
  task automatic pulse(input logic [31:0] e);
    EVENT_PULSE <= e;
    @(posedge MCLK);
    EVENT_PULSE <= 32'h0;
  endtask
  initial begin
    repeat (6) @(posedge MCLK);
    RESETN <= 1'b1;
    rd(8'h04);
    chk(rdata, 32'h0);
    rd(8'h10);
    chk(rdata, 32'h0a);
    rd(8'h14);
    chk(rdata, 32'ha2);
    wr(8'h10, 32'h2);
    foreach (rows[i]) begin
      wr(8'h04, rows[i].en);
      pulse(32'h1 << rows[i].b);
      repeat (4) @(posedge MCLK);
      chk(pin_lvl[0], rows[i].irq_n);
      rd(8'h00);
      if (!rows[i].irq_n) chk(rdata, 32'h1 << rows[i].b);
      repeat (3) @(posedge MCLK);
      chk(pin_lvl[0], 1'b1);
    end
    $display("test irq table done");
    pulse(32'h4);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdata, 32'h4);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(slverr, 1'b1);
    idle();
    XO_CLK_AVAILABLE <= 1'b0;
    pulse(32'h18000);
    rd(8'h00);
    chk(rdata, 32'h0);
    XO_CLK_AVAILABLE <= 1'b1;
    pulse(32'h10000);
    rd(8'h00);
    chk(rdata, 32'h18000);
    $display("test flags done");
    wr(8'h14, 32'h9b);
    repeat (4) @(posedge MCLK);
    chk(pin_lvl[1], 1'b1);
    chk(GPIO_HIGH_DRIVE, 4'h2);
    for (int c = 1; c < 32; c++) begin
      STATUS_LEVELS <= 32'h1 << c;
      wr(8'h1c, {24'h0, c[4:0], 3'b010});
      repeat (4) @(posedge MCLK);
      chk(pin_lvl[3], !(c inside {17, 20, 31}));
      // inverted levels prove the mux picks bit c, not any other bit
      STATUS_LEVELS <= ~(32'h1 << c);
      repeat (4) @(posedge MCLK);
      chk(pin_lvl[3], c == 19);
    end
    host_oe <= 4'h4;
    for (int c = 0; c < 6; c++) begin
      wr(8'h18, {24'h0, c[4:0], 3'b001});
      host_drv <= 4'h4;
      repeat (5) @(posedge MCLK);
      chk(fn, c < 5 ? 32'h1 << c : 32'h0);
      host_drv <= 4'h0;
      repeat (5) @(posedge MCLK);
    end
    $display("test pins done");
    wr(8'h04, 32'h1);
    pulse(32'h1);
    RESETN <= 1'b0;
    repeat (2) @(posedge MCLK);
    chk(GPIO_OE, 4'h0);
    RESETN <= 1'b1;
    rd(8'h00);
    chk(rdata, 32'h0);
    rd(8'h04);
    chk(rdata, 32'h0);
    rd(8'h10);
    chk(rdata, 32'h0a);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule // irq_and_gpio_routing_tb_top
`default_nettype wire
